// file: verilog/aux_pin_mux.sv
// Pin mux top: register slave, strap capture and registered pin outputs.
`timescale 1ns/100ps
`include "pin_mux_defines.svh"
module aux_pin_mux
#(
  parameter int ADDR_W = 16
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [2:0] indicator_src,
  input wire pin_mux_pkg::src_events_s events,
  input wire pin_mux_pkg::strap_modes_s strap_pins,
  output logic indicator_pin_zero,
  output logic indicator_pin_one,
  output logic clock_output_pin,
  output logic autonomous_enable,
  output logic [3:0] management_address_bits,
  output logic master_role,
  output logic [2:0] interface_select_bits,
  output logic [2:0] test_bits
);

  localparam int IW = ADDR_W - 2;
  localparam logic [IW-1:0] IND_IDX = IW'(`IND_CTRL_IDX);
  localparam logic [IW-1:0] CLK_IDX = IW'(`CLK_CTRL_IDX);
  localparam logic [IW-1:0] STRAP_IDX = IW'(`STRAP_IDX);

  logic [15:0] ind_ctrl_r, clk_ctrl_r;
  pin_mux_pkg::strap_modes_s strap_r;
  logic captured_r;
  logic aw_held_r, w_held_r;
  logic [IW-1:0] aw_idx_r;
  logic [15:0] w_data_r;
  logic [1:0] w_strb_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [2:0] pin_r, pin_w;
  logic autonomous_r, master_r;
  logic [3:0] addr_bits_r;
  logic [2:0] if_bits_r, test_r;

  // Write channel flow; address and data may arrive in either order.
  logic aw_hs, w_hs, do_wr;
  logic aw_held_nxt, w_held_nxt, bvalid_nxt;
  assign aw_hs = awvalid && awready_r;
  assign w_hs = wvalid && wready_r;
  assign do_wr = aw_held_r && w_held_r && !bvalid_r;
  assign aw_held_nxt = (aw_held_r || aw_hs) && !do_wr;
  assign w_held_nxt = (w_held_r || w_hs) && !do_wr;
  assign bvalid_nxt = do_wr || (bvalid_r && !bready);

  // Write decode; the strap word answers OKAY but stores nothing.
  logic wr_ind, wr_clk, wr_hit;
  logic [15:0] wmask, ind_ctrl_nxt, clk_ctrl_nxt;
  assign wr_ind = aw_idx_r == IND_IDX;
  assign wr_clk = aw_idx_r == CLK_IDX;
  assign wr_hit = wr_ind || wr_clk || (aw_idx_r == STRAP_IDX);
  assign wmask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign ind_ctrl_nxt = ((ind_ctrl_r & ~wmask) | (w_data_r & wmask)) &
                        `IND_CTRL_MASK;
  assign clk_ctrl_nxt = ((clk_ctrl_r & ~wmask) | (w_data_r & wmask)) &
                        `CLK_CTRL_MASK;

  // Write address and data holding stage.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= '0;
      w_data_r <= 16'h0000;
      w_strb_r <= 2'h0;
    end
    else
    begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      if (aw_hs)
        aw_idx_r <= awaddr[ADDR_W-1:2];
      if (w_hs)
      begin
        w_data_r <= wdata[15:0];
        w_strb_r <= wstrb[1:0];
      end
    end
  end

  // Ready is withheld while a word is parked or the answer is pending.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end
    else
    begin
      awready_r <= !aw_held_nxt && !bvalid_nxt;
      wready_r <= !w_held_nxt && !bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      if (do_wr)
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // Control registers; the reset values pick indicator and clock sources.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ind_ctrl_r <= `IND_CTRL_RST;
      clk_ctrl_r <= `CLK_CTRL_RST;
    end
    else if (do_wr && wr_ind)
      ind_ctrl_r <= ind_ctrl_nxt;
    else if (do_wr && wr_clk)
      clk_ctrl_r <= clk_ctrl_nxt;
  end

  // Read decode; an unmapped word reads zero with SLVERR.
  logic ar_hs, rvalid_nxt, rd_hit;
  logic [IW-1:0] rd_idx;
  logic [15:0] rd_word;
  assign ar_hs = arvalid && arready_r;
  assign rvalid_nxt = ar_hs || (rvalid_r && !rready);
  assign rd_idx = araddr[ADDR_W-1:2];
  assign rd_hit = (rd_idx == IND_IDX) || (rd_idx == CLK_IDX) ||
                  (rd_idx == STRAP_IDX);
  assign rd_word = (rd_idx == IND_IDX) ? ind_ctrl_r :
                   (rd_idx == CLK_IDX) ? clk_ctrl_r :
                   (rd_idx == STRAP_IDX) ? strap_r : 16'h0000;

  // Read channel; one read in flight, data held until taken.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end
    else
    begin
      arready_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_hs)
      begin
        rdata_r <= {16'h0000, rd_word};
        rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // Straps are caught at the first edge after reset and then frozen, so a
  // pin later reused as an output cannot disturb the configuration.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      captured_r <= 1'b0;
      strap_r <= '0;
      autonomous_r <= 1'b0;
      master_r <= 1'b0;
      addr_bits_r <= 4'h0;
      if_bits_r <= 3'h0;
      test_r <= 3'h0;
    end
    else if (!captured_r)
    begin
      captured_r <= 1'b1;
      strap_r <= strap_pins;
      autonomous_r <= strap_pins.autonomous == 2'h0;
      master_r <= strap_pins.link_role == 2'h3;
      // Mode index m gives the pair {m[1], m[1] ^ m[0]}: 00, 01, 11, 10.
      addr_bits_r <= {^strap_pins.addr_odd, ^strap_pins.addr_even,
                      strap_pins.addr_odd[1],
                      strap_pins.addr_even[1]};
      if_bits_r <= {strap_pins.rxd2[1], strap_pins.rxd1[1],
                    strap_pins.rxd0[1]};
      test_r <= {^strap_pins.rxd2, ^strap_pins.rxd1,
                 ^strap_pins.rxd0};
    end
  end

  // Per-pin selector fields; pin 2 is the clock-out pin.
  logic [2:0] src_sel_w [3];
  logic [3:0] clk_sel_w [3];
  assign src_sel_w[0] = ind_ctrl_r[`P0_SEL_LSB +: 3];
  assign src_sel_w[1] = ind_ctrl_r[`P1_SEL_LSB +: 3];
  assign src_sel_w[2] = clk_ctrl_r[`CO_SEL_LSB +: 3];
  assign clk_sel_w[0] = {1'b0, ind_ctrl_r[`P0_CLK_LSB +: 3]};
  assign clk_sel_w[1] = {1'b0, ind_ctrl_r[`P1_CLK_LSB +: 3]};
  assign clk_sel_w[2] = clk_ctrl_r[`CO_CLK_LSB +: 4];

  // One selector per pin; code zero picks that pin's own indicator.
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_pin
      pin_source_mux pin_source_mux_i (
        .src_sel(src_sel_w[g]),
        .clk_sel(clk_sel_w[g]),
        .own_indicator(indicator_src[g]),
        .events(events),
        .pin_level(pin_w[g])
      );
    end
  endgenerate

  // Pins are retimed; a selected clock is therefore sampled at sys_clk.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pin_r <= 3'h0;
    else
      pin_r <= pin_w;
  end

  // Port assignments, all from flip-flops.
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign indicator_pin_zero = pin_r[0];
  assign indicator_pin_one = pin_r[1];
  assign clock_output_pin = pin_r[2];
  assign autonomous_enable = autonomous_r;
  assign master_role = master_r;
  assign management_address_bits = addr_bits_r;
  assign interface_select_bits = if_bits_r;
  assign test_bits = test_r;

  // Checks on the pin paths, the strap decode, the reserved control bits and the write answer.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_pin0_high;
    (src_sel_w[0] == pin_mux_pkg::SRC_HIGH) |=> indicator_pin_zero;
  endproperty
  a_pin0_high: assert property (p_pin0_high)
    else $error("pin zero not high for constant one");

  property p_pin1_low;
    (src_sel_w[1] == pin_mux_pkg::SRC_LOW) |=> !indicator_pin_one;
  endproperty
  a_pin1_low: assert property (p_pin1_low)
    else $error("pin one not low for constant zero");

  property p_clock_output_pin_ind2;
    (src_sel_w[2] == pin_mux_pkg::SRC_IND)
      |=> clock_output_pin == $past(indicator_src[2]);
  endproperty
  a_clock_output_pin_ind2: assert property (p_clock_output_pin_ind2)
    else $error("clock-out does not follow indicator two");

  property p_pin1_line;
    (src_sel_w[1] == pin_mux_pkg::SRC_CLOCK && clk_sel_w[1] == 4'h1)
      |=> indicator_pin_one == $past(events.transmit_line_clock);
  endproperty
  a_pin1_line: assert property (p_pin1_line)
    else $error("pin one does not follow line clock");

  property p_pin0_xtal;
    (src_sel_w[0] == pin_mux_pkg::SRC_CLOCK && clk_sel_w[0] == 4'h0)
      |=> indicator_pin_zero == $past(events.crystal_input_clock);
  endproperty
  a_pin0_xtal: assert property (p_pin0_xtal)
    else $error("pin zero does not follow crystal clock");

  property p_clock_output_pin_xtal;
    (src_sel_w[2] == pin_mux_pkg::SRC_CLOCK && clk_sel_w[2] == 4'h0)
      |=> clock_output_pin == $past(events.crystal_input_clock);
  endproperty
  a_clock_output_pin_xtal: assert property (p_clock_output_pin_xtal)
    else $error("clock-out does not follow crystal clock");

  property p_auto;
    captured_r |-> autonomous_enable == (strap_r.autonomous == 2'h0);
  endproperty
  a_auto: assert property (p_auto)
    else $error("autonomous enable disagrees with strap");

  property p_addr;
    captured_r |-> management_address_bits ==
      {strap_r.addr_odd[1] ^ strap_r.addr_odd[0],
       strap_r.addr_even[1] ^ strap_r.addr_even[0],
       strap_r.addr_odd[1], strap_r.addr_even[1]};
  endproperty
  a_addr: assert property (p_addr)
    else $error("management address bits disagree with straps");

  property p_role;
    captured_r |-> master_role == (strap_r.link_role == 2'h3);
  endproperty
  a_role: assert property (p_role)
    else $error("link role disagrees with strap");

  property p_ifsel;
    captured_r |-> interface_select_bits ==
      {strap_r.rxd2[1], strap_r.rxd1[1], strap_r.rxd0[1]};
  endproperty
  a_ifsel: assert property (p_ifsel)
    else $error("interface select bits disagree with straps");

  property p_frozen;
    captured_r |=> $stable(strap_r) && captured_r;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("strap status changed after capture");

  property p_strap_read;
    (ar_hs && rd_idx == STRAP_IDX) |=> rdata == {16'h0000, strap_r};
  endproperty
  a_strap_read: assert property (p_strap_read)
    else $error("strap read does not return captured modes");

  property p_reserved;
    ((ind_ctrl_r & ~`IND_CTRL_MASK) == 16'h0000) &&
    ((clk_ctrl_r & ~`CLK_CTRL_MASK) == 16'h0000);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bits not zero");

  property p_write_resp;
    (aw_hs && w_hs) |=> ##1 bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write answer not two cycles after request");

  c_ind_write: cover property (do_wr && wr_ind);
  c_strap_read: cover property (ar_hs && rd_idx == STRAP_IDX);
  c_clock_output_pin_line: cover property (src_sel_w[2] == 3'h1 && clk_sel_w[2] == 4'h1);
  c_b_stall: cover property (bvalid && !bready ##1 bvalid && bready);

endmodule

// file: verilog/pin_mux_defines.svh
// Register map, field positions, reset values and codes of the pin mux.
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

// Register indexes; the byte address is four times the index.
`define IND_CTRL_IDX 16'h0462
`define CLK_CTRL_IDX 16'h0463
`define STRAP_IDX 16'h0467

// Reset values and writable-bit masks.
`define IND_CTRL_RST 16'h0000
`define CLK_CTRL_RST 16'h0001
`define IND_CTRL_MASK 16'h7777
`define CLK_CTRL_MASK 16'h00f7

// Field positions.
`define P0_SEL_LSB 0
`define P0_CLK_LSB 4
`define P1_SEL_LSB 8
`define P1_CLK_LSB 12
`define CO_SEL_LSB 0
`define CO_CLK_LSB 4

// Clock source codes and bus responses.
`define CLK_SEL_XTAL 4'h0
`define CLK_SEL_LINE 4'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: verilog/pin_mux_pkg.sv
// Types shared by the pin mux modules.
package pin_mux_pkg;

  // Source codes of a pin selector.
  typedef enum logic [2:0] {
    SRC_IND = 3'h0,
    SRC_CLOCK = 3'h1,
    SRC_WAKE = 3'h2,
    SRC_UNDERVOLT = 3'h3,
    SRC_TS_TX = 3'h4,
    SRC_TS_RX = 3'h5,
    SRC_LOW = 3'h6,
    SRC_HIGH = 3'h7
  } pin_src_e;

  // Strap modes in register order, first field in bits 15:14.
  typedef struct packed {
    logic [1:0] autonomous;
    logic [1:0] addr_even;
    logic [1:0] addr_odd;
    logic [1:0] link_role;
    logic [1:0] rxd0;
    logic [1:0] rxd1;
    logic [1:0] rxd2;
    logic [1:0] rxd3;
  } strap_modes_s;

  // Shared sources that any pin may select.
  typedef struct packed {
    logic wake_event;
    logic undervoltage_flag;
    logic ts_transmit;
    logic ts_receive;
    logic crystal_input_clock;
    logic transmit_line_clock;
  } src_events_s;

endpackage

// file: verilog/pin_source_mux.sv
// Source selector for one multipurpose pin.
`timescale 1ns/100ps
`include "pin_mux_defines.svh"
module pin_source_mux
(
  input wire logic [2:0] src_sel,
  input wire logic [3:0] clk_sel,
  input wire logic own_indicator,
  input wire pin_mux_pkg::src_events_s events,
  output logic pin_level
);

  logic clk_level;
  logic [7:0] choices;

  // Unlisted clock codes give a quiet low level rather than a guess.
  assign clk_level = (clk_sel == `CLK_SEL_XTAL) ?
                     events.crystal_input_clock :
                     (clk_sel == `CLK_SEL_LINE) ?
                     events.transmit_line_clock : 1'b0;

  // Candidates in code order, index 0 is the pin's own indicator.
  assign choices = {1'b1, 1'b0, events.ts_receive, events.ts_transmit,
                    events.undervoltage_flag, events.wake_event,
                    clk_level, own_indicator};
  assign pin_level = choices[src_sel];

endmodule

// file: sim/lamp_load.sv
// Board load model: indicator lamps and clock consumers counting rising pin edges.
`timescale 1ns/100ps
module lamp_load
(
  input wire logic sys_clk,
  input wire logic clr,
  input wire logic [2:0] pins,
  output logic [2:0][7:0] rises
);
  logic [2:0] prev_r;

  // A consumer sees the pin only at its own sampling edge, never in between.
  always_ff @(posedge sys_clk)
  begin
    prev_r <= pins;
    for (int i = 0; i < 3; i++)
    begin
      if (clr)
        rises[i] <= 8'h00;
      else if (pins[i] && !prev_r[i])
        rises[i] <= rises[i] + 8'h01;
    end
  end
endmodule

// file: sim/phy_aux_pin_mux_strap_status_test.sv
// Self-checking testbench of the auxiliary pin mux and strap status.
`timescale 1ns/100ps
`include "pin_mux_defines.svh"
module phy_aux_pin_mux_strap_status_test;
  logic sys_clk, rst, awvalid, wvalid, bready, arvalid, rready, clr;
  logic awready, wready, bvalid, arready, rvalid, autonomous_enable;
  logic indicator_pin_zero, indicator_pin_one, clock_output_pin, master_role;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, management_address_bits;
  logic [1:0] bresp, rresp;
  logic [2:0] indicator_src, interface_select_bits, test_bits;
  logic [2:0][7:0] rises;
  pin_mux_pkg::src_events_s events;
  pin_mux_pkg::strap_modes_s strap_pins;
  int error_cnt, total_checks;

  aux_pin_mux aux_pin_mux_i (.sys_clk, .rst, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .indicator_src,
    .events, .strap_pins, .indicator_pin_zero, .indicator_pin_one,
    .clock_output_pin, .autonomous_enable, .management_address_bits,
    .master_role, .interface_select_bits, .test_bits);

  lamp_load lamp_load_i (.sys_clk, .clr, .rises,
    .pins({clock_output_pin, indicator_pin_one, indicator_pin_zero}));

  // Free-running 40 MHz clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus write; valids drop once taken, so a late ready cannot double-issue.
  task automatic wr(input logic [15:0] idx, input logic [15:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    int n;
    awaddr <= {idx[13:0], 2'b00};
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge sys_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    if (n == 40)
    begin
      error_cnt++;
      close_out();
    end
    chk_val({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Bus read, judged against the expected word and response.
  task automatic rd(input logic [15:0] idx, input logic [15:0] ed,
                    input logic [1:0] er);
    int n;
    araddr <= {idx[13:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge sys_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    if (n == 40)
    begin
      error_cnt++;
      close_out();
    end
    chk_val(rdata, {16'h0000, ed});
    chk_val({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic do_reset(input logic [15:0] s);
    strap_pins <= s;
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // Decoded strap outputs: mode index, then the pair of configuration bits.
  function automatic logic [11:0] dec(input logic [15:0] s);
    return {s[15:14] == 2'h0, s[9:8] == 2'h3, s[11] ^ s[10], s[13] ^ s[12],
      s[11], s[13], s[3], s[5], s[7], s[3] ^ s[2], s[5] ^ s[4], s[7] ^ s[6]};
  endfunction

  // Expected pin level; v holds events above the three own indicators.
  function automatic logic sel(input int p, input logic [2:0] c,
                               input logic [8:0] v);
    case (c)
      3'h0: return v[p];
      3'h1: return v[4];
      3'h2: return v[8];
      3'h3: return v[7];
      3'h4: return v[6];
      3'h5: return v[5];
      3'h6: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction

  // Straps move after capture, so a live copy instead of a latch shows up.
  task automatic t_straps();
    logic [15:0] tbl [5] = '{16'h0000, 16'h5555, 16'haaaa, 16'hffff, 16'h1be4};
    foreach (tbl[k])
    begin
      do_reset(tbl[k]);
      strap_pins <= ~tbl[k];
      rd(`IND_CTRL_IDX, `IND_CTRL_RST, `RESP_OKAY);
      rd(`CLK_CTRL_IDX, `CLK_CTRL_RST, `RESP_OKAY);
      rd(`STRAP_IDX, tbl[k], `RESP_OKAY);
      chk_val({20'h0, autonomous_enable, master_role, management_address_bits,
        interface_select_bits, test_bits}, {20'h0, dec(tbl[k])});
      wr(`STRAP_IDX, ~tbl[k], 4'h3, `RESP_OKAY);
      rd(`STRAP_IDX, tbl[k], `RESP_OKAY);
    end
  endtask

  // Reserved bits, byte lanes and an unmapped word.
  task automatic t_regs();
    wr(`IND_CTRL_IDX, 16'hffff, 4'hf, `RESP_OKAY);
    rd(`IND_CTRL_IDX, `IND_CTRL_MASK, `RESP_OKAY);
    wr(`CLK_CTRL_IDX, 16'hffff, 4'hf, `RESP_OKAY);
    rd(`CLK_CTRL_IDX, `CLK_CTRL_MASK, `RESP_OKAY);
    wr(`IND_CTRL_IDX, 16'h0000, 4'h1, `RESP_OKAY);
    rd(`IND_CTRL_IDX, 16'h7700, `RESP_OKAY);
    wr(16'h0464, 16'hffff, 4'hf, `RESP_SLVERR);
    rd(16'h0464, 16'h0000, `RESP_SLVERR);
  endtask

  // A single high source walks past every code, so a wrong pick shows.
  task automatic t_sources();
    logic [8:0] v;
    for (int c = 0; c < 8; c++)
    begin
      wr(`IND_CTRL_IDX, {5'h00, c[2:0], 5'h00, c[2:0]}, 4'h3, `RESP_OKAY);
      wr(`CLK_CTRL_IDX, {13'h0000, c[2:0]}, 4'h3, `RESP_OKAY);
      for (int b = 0; b < 10; b++)
      begin
        v = 9'h001 << b;
        {events, indicator_src} <= v;
        repeat (2) @(posedge sys_clk);
        chk_val({29'h0, clock_output_pin, indicator_pin_one,
          indicator_pin_zero}, {29'h0, sel(2, c[2:0], v), sel(1, c[2:0], v),
          sel(0, c[2:0], v)});
      end
    end
  endtask

  // Toggle one clock source sixteen times and count what the loads see.
  task automatic run(input logic [15:0] ind, input logic [15:0] co,
                     input logic line, input logic [7:0] n);
    wr(`IND_CTRL_IDX, ind, 4'h3, `RESP_OKAY);
    wr(`CLK_CTRL_IDX, co, 4'h3, `RESP_OKAY);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (16)
    begin
      @(posedge sys_clk);
      if (line)
        events.transmit_line_clock <= ~events.transmit_line_clock;
      else
        events.crystal_input_clock <= ~events.crystal_input_clock;
    end
    repeat (3) @(posedge sys_clk);
    chk_val({8'h00, rises}, {8'h00, n, n, n});
  endtask

  initial
  begin
    error_cnt = 0;
    total_checks = 0;
    rst = 1'b1;
    clr = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    indicator_src = 3'h0;
    events = '0;
    strap_pins = '0;
    @(posedge sys_clk);
    t_straps();
    t_regs();
    t_sources();
    run(16'h0101, 16'h0001, 1'b0, 8'h08);
    run(16'h1111, 16'h0011, 1'b0, 8'h00);
    run(16'h1111, 16'h0011, 1'b1, 8'h08);
    close_out();
  end
endmodule
